// [src/pulse_pkg.sv]
// shared constants and carrier types for the fast channel pulse counter
// Operation
// - A new ADC sample is taken every 50 ns (20 MHz) and fed into the digital filter path.
// - Peak values are found directly from the samples with no conversion gap that ignores input.
// - The fast shaper has a fixed 400 ns peaking time and only its rising part forms the dead period.
// - A second event within 400 ns of the previous one adds no separate fast count.
// - Every detected event, counted or not, restarts the 400 ns dead window, so the counter is paralyzable.
// - The acquisition clock keeps running through fast dead periods.
// - The shaper makes symmetric triangles that return to baseline after two peaking times.
// - A first-stage gain select output picks gain 5 or 10 and changes only on processor command.
// - A final-stage gain select output picks extra gain of about 2 or 10 through the same switch control.
// - The acquisition clock stops during serial transfers and preamp reset intervals.
package pulse_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned SAMPLE_NS     = 50;
  localparam int unsigned FAST_PEAK_NS  = 400;
  localparam int unsigned FAST_PEAK_CYC = (FAST_PEAK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned ADC_W         = 12;
  localparam int unsigned SHAPE_W       = ADC_W + 5;
  localparam int unsigned CNT_W         = 32;
  localparam logic        GAIN1_RST     = 1'b0;
  localparam logic        GAIN2_RST     = 1'b0;

  typedef struct packed {
    logic first_hi;
    logic final_hi;
  } gain_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RISE = 3'b010,
    ST_FALL = 3'b100
  } peak_e;
endpackage : pulse_pkg

// [src/fast_shaper.sv]
// triangular shaper built from a delay line of samples
`timescale 1ns/1ps
`default_nettype none
module fast_shaper #(
  parameter int unsigned W = pulse_pkg::ADC_W,
  parameter int unsigned K = pulse_pkg::FAST_PEAK_CYC
) (
  input  wire logic                              clk,     // sample clock
  input  wire logic                              rst,     // synchronous reset
  input  wire logic [W-1:0]                      din,     // sample
  output logic      [pulse_pkg::SHAPE_W-1:0]     shaped_q // signed triangle output
);
  logic [W-1:0] dly_q [0:2*K-1];
  logic signed [pulse_pkg::SHAPE_W-1:0] acc_q;
  logic signed [pulse_pkg::SHAPE_W-1:0] step_d;

  // x[n] - 2x[n-K] + x[n-2K]: rise K samples, fall K samples, zero after 2K
  assign step_d = $signed({5'h00, din}) - $signed({4'h0, dly_q[K-1], 1'b0})
                + $signed({5'h00, dly_q[2*K-1]});

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 2*K; i++) dly_q[i] <= '0;
    end else begin
      dly_q[0] <= din;
      for (int i = 1; i < 2*K; i++) dly_q[i] <= dly_q[i-1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) acc_q <= '0;
    else acc_q <= acc_q + step_d;
  end

  // triangle is the running sum of step_d, passed out unscaled (peak is K times the step)
  assign shaped_q = acc_q;
endmodule : fast_shaper
`default_nettype wire

// [src/fast_channel_pulse_counter.sv]
// fast channel counter, peak finder, live clock and gain switches
`timescale 1ns/1ps
`default_nettype none
module fast_channel_pulse_counter #(
  parameter int unsigned ADC_W = pulse_pkg::ADC_W,
  parameter int unsigned CNT_W = pulse_pkg::CNT_W
) (
  input  wire logic                          ref_clk,      // 20 MHz sample clock
  input  wire logic                          sys_rst,      // synchronous reset, active high
  input  wire logic [ADC_W-1:0]              adc_data,     // ADC sample, same clock
  input  wire logic [pulse_pkg::SHAPE_W-1:0] fast_thresh,  // fast threshold, signed
  input  wire logic                          xfer_busy,    // serial transfer in progress (pin)
  input  wire logic                          preamp_reset, // preamp reset interval (pin)
  input  wire logic                          gain_cmd,     // processor command strobe
  input  wire pulse_pkg::gain_s              gain_req,     // requested gain settings
  output logic [CNT_W-1:0]                   fast_count_q, // fast counts
  output logic [CNT_W-1:0]                   acq_time_q,   // live acquisition ticks
  output logic [pulse_pkg::SHAPE_W-1:0]      peak_val_q,   // last peak value
  output logic                               peak_vld_q,   // one-cycle peak strobe
  output logic                               fast_event_q, // one-cycle event strobe
  output logic                               dead_q,       // fast channel dead
  output pulse_pkg::gain_s                   gain_sel_q    // gain switch drives
);
  localparam int unsigned K   = pulse_pkg::FAST_PEAK_CYC;
  localparam int unsigned DCW = $clog2(K+1);

  // signed greater-than on shaped values, shared by threshold and peak finder
  function automatic logic exceeds(
    input logic signed [pulse_pkg::SHAPE_W-1:0] a,
    input logic signed [pulse_pkg::SHAPE_W-1:0] b
  );
    return a > b;
  endfunction : exceeds

  logic        [ADC_W-1:0]              sample_q;
  logic        [1:0]                    xfer_s_q;
  logic        [1:0]                    prst_s_q;
  logic                                 xfer_busy_s;
  logic                                 prst_s;
  logic                                 acq_run;
  logic        [pulse_pkg::SHAPE_W-1:0] shaped;
  logic signed [pulse_pkg::SHAPE_W-1:0] shp_q;
  logic signed [pulse_pkg::SHAPE_W-1:0] pmax_q;
  logic                                 above;
  logic                                 above_q;
  logic                                 rise_edge;
  logic                                 counted;
  logic        [DCW-1:0]                dead_cnt_q;
  pulse_pkg::peak_e                     pst_q;

  // sample register: one new sample every cycle, no gaps
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sample_q <= '0;
    end else begin
      sample_q <= adc_data;
    end
  end

  fast_shaper #(
    .W (ADC_W),
    .K (K)
  ) u_shaper (
    .clk      (ref_clk),
    .rst      (sys_rst),
    .din      (sample_q),
    .shaped_q (shaped)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shp_q <= '0;
    end else begin
      shp_q <= $signed(shaped);
    end
  end

  // threshold crossing and its rising edge
  assign above     = exceeds(shp_q, $signed(fast_thresh));
  assign rise_edge = above && !above_q;
  // only a crossing with the window closed adds a count
  assign counted   = rise_edge && (dead_cnt_q == '0);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      above_q <= 1'b0;
    end else begin
      above_q <= above;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fast_event_q <= 1'b0;
    end else begin
      fast_event_q <= rise_edge;
    end
  end

  // dead window restarts on every event, counted or not
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dead_cnt_q <= '0;
    end else if (rise_edge) begin
      dead_cnt_q <= DCW'(K);
    end else if (dead_cnt_q != '0) begin
      dead_cnt_q <= dead_cnt_q - DCW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dead_q <= 1'b0;
    end else begin
      dead_q <= rise_edge || (dead_cnt_q > DCW'(1));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fast_count_q <= '0;
    end else if (counted) begin
      fast_count_q <= fast_count_q + 1'b1;
    end
  end

  // peak finder runs every sample, no conversion blackout
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pst_q      <= pulse_pkg::ST_IDLE;
      pmax_q     <= '0;
      peak_val_q <= '0;
      peak_vld_q <= 1'b0;
    end else begin
      peak_vld_q <= 1'b0;
      case (pst_q)
        pulse_pkg::ST_IDLE: begin
          if (above) begin
            pmax_q <= shp_q;
            pst_q  <= pulse_pkg::ST_RISE;
          end
        end
        pulse_pkg::ST_RISE: begin
          if (!exceeds(pmax_q, shp_q)) begin
            pmax_q <= shp_q;
          end else begin
            peak_val_q <= pmax_q;
            peak_vld_q <= 1'b1;
            pst_q      <= pulse_pkg::ST_FALL;
          end
        end
        pulse_pkg::ST_FALL: begin
          if (!above) begin
            pst_q <= pulse_pkg::ST_IDLE;
          end else if (exceeds(shp_q, pmax_q)) begin
            // a fresh rise on the tail: track the new pulse
            pmax_q <= shp_q;
            pst_q  <= pulse_pkg::ST_RISE;
          end else begin
            pmax_q <= shp_q;
          end
        end
        default: begin
          pst_q <= pulse_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // pin inputs cross two flops before use
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      xfer_s_q <= '0;
    end else begin
      xfer_s_q <= {xfer_s_q[0], xfer_busy};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prst_s_q <= '0;
    end else begin
      prst_s_q <= {prst_s_q[0], preamp_reset};
    end
  end

  assign xfer_busy_s = xfer_s_q[1];
  assign prst_s      = prst_s_q[1];
  // fast dead time is deliberately not part of this gate
  assign acq_run     = !xfer_busy_s && !prst_s;

  // live time halts only on transfer or preamp reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acq_time_q <= '0;
    end else if (acq_run) begin
      acq_time_q <= acq_time_q + 1'b1;
    end
  end

  // first stage switch moves only on a processor command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gain_sel_q.first_hi <= pulse_pkg::GAIN1_RST;
    end else if (gain_cmd) begin
      gain_sel_q.first_hi <= gain_req.first_hi;
    end
  end

  // final stage switch shares the same command strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gain_sel_q.final_hi <= pulse_pkg::GAIN2_RST;
    end else if (gain_cmd) begin
      gain_sel_q.final_hi <= gain_req.final_hi;
    end
  end
endmodule : fast_channel_pulse_counter
`default_nettype wire

// [tb/adc_model.sv]
// sampling ADC model that turns step requests into a staircase of samples
`timescale 1ns/1ps
`default_nettype none
module adc_model #(
  parameter logic [11:0] STEP = 12'h190
) (
  input  wire logic        ref_clk,  // sample clock
  input  wire logic        fire,     // add one charge step at the next sample
  output logic      [11:0] adc_data  // converted sample
);
  initial adc_data = 12'h000;
  // one charge step added at each clock edge that sees fire, sample held otherwise
  always @(posedge ref_clk) if (fire) adc_data <= adc_data + STEP;
endmodule : adc_model
`default_nettype wire

// [tb/fcpc_chk.sv]
// port level checks for the fast channel pulse counter
`timescale 1ns/1ps
`default_nettype none
module fcpc_chk #(parameter int unsigned ADC_W = pulse_pkg::ADC_W, CNT_W = pulse_pkg::CNT_W) (
  input wire logic ref_clk, sys_rst, xfer_busy, preamp_reset, gain_cmd, peak_vld_q, fast_event_q, dead_q,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic [pulse_pkg::SHAPE_W-1:0] fast_thresh, peak_val_q,
  input wire logic [CNT_W-1:0] fast_count_q, acq_time_q,
  input wire pulse_pkg::gain_s gain_req, gain_sel_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_GAIN_LOAD: assert property (gain_cmd |=> gain_sel_q == $past(gain_req)) else $error("gain not loaded");
  AST_GAIN_HOLD: assert property (!gain_cmd |=> $stable(gain_sel_q)) else $error("gain moved");
  AST_ACQ_RUN: assert property ((!xfer_busy && !preamp_reset)[*3] |=> acq_time_q == $past(acq_time_q) + 1)
    else $error("live clock stalled");
  AST_ACQ_STOP: assert property ((xfer_busy || preamp_reset)[*3] |=> $stable(acq_time_q)) else $error("clock ran");
  AST_COUNT_STEP: assert property (fast_count_q != $past(fast_count_q) |-> fast_event_q
    && fast_count_q == $past(fast_count_q) + 1) else $error("bad count step");
  AST_DEAD_ON: assert property (fast_event_q |-> dead_q[*7]) else $error("dead window short");
  AST_HOLDOFF: assert property (fast_event_q |=> $stable(fast_count_q)[*7]) else $error("counted while dead");
  AST_PEAK: assert property (fast_event_q |-> ##[1:24] peak_vld_q) else $error("no peak found");
  cover property (fast_event_q);
  cover property (peak_vld_q);
  cover property (gain_cmd);
endmodule : fcpc_chk
bind fast_channel_pulse_counter fcpc_chk #(.ADC_W(ADC_W), .CNT_W(CNT_W)) u_chk (
  .ref_clk      (ref_clk),
  .sys_rst      (sys_rst),
  .xfer_busy    (xfer_busy),
  .preamp_reset (preamp_reset),
  .gain_cmd     (gain_cmd),
  .peak_vld_q   (peak_vld_q),
  .fast_event_q (fast_event_q),
  .dead_q       (dead_q),
  .adc_data     (adc_data),
  .fast_thresh  (fast_thresh),
  .peak_val_q   (peak_val_q),
  .fast_count_q (fast_count_q),
  .acq_time_q   (acq_time_q),
  .gain_req     (gain_req),
  .gain_sel_q   (gain_sel_q)
);
`default_nettype wire

// [tb/tb_fast_channel_pulse_counter.sv]
// self-checking bench for the fast channel pulse counter
`timescale 1ns/1ps
`default_nettype none
module tb_fast_channel_pulse_counter;
  logic ref_clk = 1'b0, sys_rst = 1'b1, xfer_busy = 1'b0, preamp_reset = 1'b0, gain_cmd = 1'b0, fire = 1'b0;
  logic        peak_vld_q, fast_event_q, dead_q;
  logic [11:0] adc_data;
  logic [16:0] fast_thresh = 17'h00064, peak_val_q, pk;
  logic [31:0] fast_count_q, acq_time_q, t0;
  pulse_pkg::gain_s gain_req = '0, gain_sel_q;
  int errors = 0, total_checks = 0;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (peak_vld_q === 1'b1) pk <= peak_val_q;
  adc_model MDL (
    .ref_clk  (ref_clk),
    .fire     (fire),
    .adc_data (adc_data)
  );
  fast_channel_pulse_counter DUT (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .adc_data     (adc_data),
    .fast_thresh  (fast_thresh),
    .xfer_busy    (xfer_busy),
    .preamp_reset (preamp_reset),
    .gain_cmd     (gain_cmd),
    .gain_req     (gain_req),
    .fast_count_q (fast_count_q),
    .acq_time_q   (acq_time_q),
    .peak_val_q   (peak_val_q),
    .peak_vld_q   (peak_vld_q),
    .fast_event_q (fast_event_q),
    .dead_q       (dead_q),
    .gain_sel_q   (gain_sel_q)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_cyc
  task automatic step(input int gap);
    fire = 1'b1;
    wait_cyc(1);
    fire = 1'b0;
    wait_cyc(gap);
  endtask : step
  task automatic t_gain;
    for (int i = 0; i < 4; i++) begin
      gain_req = i[1:0];
      gain_cmd = 1'b1;
      wait_cyc(1);
      gain_cmd = 1'b0;
      gain_req = ~i[1:0];
      wait_cyc(3);
      check(gain_sel_q, i);
    end
  endtask : t_gain
  task automatic t_pulses;
    t0 = fast_count_q;
    step(40);
    check(fast_count_q, t0 + 1);
    check(pk, 17'h00C80);
    step(3);
    step(40);
    check(fast_count_q, t0 + 2);
    step(20);
    step(40);
    check(fast_count_q, t0 + 4);
  endtask : t_pulses
  task automatic t_acq;
    for (int i = 0; i < 2; i++) begin
      {xfer_busy, preamp_reset} = i ? 2'b01 : 2'b10;
      wait_cyc(4);
      t0 = acq_time_q;
      step(9);
      check(acq_time_q, t0);
      {xfer_busy, preamp_reset} = 2'b00;
      wait_cyc(4);
      t0 = acq_time_q;
      step(9);
      check(acq_time_q, t0 + 10);
      wait_cyc(30);
    end
  endtask : t_acq
  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    wait_cyc(5);
    sys_rst = 1'b0;
    wait_cyc(20);
    check(gain_sel_q, 0);
    t_gain;
    t_pulses;
    t_acq;
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    complete_run;
  end
endmodule : tb_fast_channel_pulse_counter
`default_nettype wire
